// ---- core/efp_ctrl.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Exact-frequency fractional synthesizer control
// ------------------------------------------------------------------
module efp_ctrl #(
   parameter int POR_CYCLES = efp_pkg::EFP_POR_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [4:0] wr_addr,
   input wire logic [efp_pkg::EFP_DW-1:0] wr_data,
   input wire logic [4:0] rd_addr,
   input wire logic chip_enable_pin,
   output logic [efp_pkg::EFP_DW-1:0] rd_data,
   output logic power_down,
   output logic clocks_run,
   output logic por_busy,
   output logic frac_mode,
   output logic [efp_pkg::EFP_DW-1:0] int_ratio,
   output logic [efp_pkg::EFP_DW-1:0] step_count,
   output logic [efp_pkg::EFP_DW-1:0] accum_phase,
   output logic mod_carry,
   output logic seed_reload
);
   import efp_pkg::*;

   typedef struct packed {
      logic [31:0] por_cnt;
      logic por;
      logic [23:0] pwr;
      logic [23:0] intg;
      logic [23:0] frac;
      logic [23:0] modc;
      logic [23:0] step;
      logic [23:0] seed;
      logic [4:0] rsel;
      logic [1:0] cen_sync;
      logic pd;
      logic run;
      logic load;
      logic [23:0] rdat;
      logic [23:0] ph;
      logic cy;
   } efp_st_t;

   efp_st_t st_reg;
   efp_st_t st_next;
   logic [23:0] acc_phase;
   logic acc_carry;
   logic acc_load;
   logic acc_run;

   // Register readback decode.
   function automatic logic [23:0] rd_mux(input efp_st_t s, input logic [4:0] a);
      case (a)
         EFP_ADDR_RST: rd_mux = EFP_CHIP_ID;
         EFP_ADDR_PWR: rd_mux = s.pwr;
         EFP_ADDR_INT: rd_mux = s.intg;
         EFP_ADDR_FRAC: rd_mux = s.frac;
         EFP_ADDR_MOD: rd_mux = s.modc;
         EFP_ADDR_STEP: rd_mux = s.step;
         EFP_ADDR_SEED: rd_mux = s.seed;
         default: rd_mux = 24'h00_0000;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.load = 1'b0;
      st_next.cen_sync = {st_reg.cen_sync[0], chip_enable_pin};
      // Power-on hold counts up to POR_CYCLES-1, then clears; registers keep the values loaded at reset.
      if (st_reg.por) begin
         if (st_reg.por_cnt == 32'(POR_CYCLES - 1)) begin
            st_next.por = 1'b0;
         end else begin
            st_next.por_cnt = st_reg.por_cnt + 32'd1;
         end
      end
      // Writes are honoured in power-down too; ignored during POR.
      if (wr_en && !st_reg.por) begin
         case (wr_addr)
            EFP_ADDR_RST: begin
               st_next.pwr = EFP_RST_PWR;
               st_next.intg = EFP_RST_INT;
               st_next.frac = EFP_RST_FRAC;
               st_next.modc = EFP_RST_MOD;
               st_next.step = EFP_RST_STEP;
               st_next.seed = EFP_RST_SEED;
               st_next.rsel = wr_data[4:0];
            end
            EFP_ADDR_PWR: st_next.pwr = wr_data;
            EFP_ADDR_INT: st_next.intg = wr_data;
            EFP_ADDR_FRAC: begin
               st_next.frac = wr_data;
               st_next.load = 1'b1;
            end
            EFP_ADDR_MOD: st_next.modc = wr_data;
            EFP_ADDR_STEP: st_next.step = wr_data;
            EFP_ADDR_SEED: st_next.seed = wr_data;
            default: st_next.pwr = st_reg.pwr;
         endcase
      end
      // Power-down source: pin when override set, else register bit.
      if (st_reg.pwr[EFP_PWR_OVR_BIT]) begin
         st_next.pd = ~st_reg.cen_sync[1];
      end else begin
         st_next.pd = st_reg.pwr[EFP_PWR_REG_BIT];
      end
      // Clock-run flag is registered alongside power-down, never gated after the flop.
      st_next.run = ~st_next.pd;
      st_next.rdat = rd_mux(st_reg, rd_addr);
      st_next.ph = acc_phase;
      st_next.cy = acc_carry;
   end

   // Seed applies only with exact mode (nonzero step), whether or not the modulator is on.
   assign acc_load = st_reg.load && (st_reg.step != 24'h00_0000);
   // Modulator halts in power-down; registers untouched.
   assign acc_run = st_reg.modc[EFP_MOD_FRAC_EN_BIT] && !st_reg.pd;

   efp_accum #(.W(EFP_DW)) u_accum (
      .clk(clk),
      .rst(rst),
      .run(acc_run),
      .load(acc_load),
      .seed(st_reg.seed),
      .step(st_reg.frac),
      .phase(acc_phase),
      .carry(acc_carry)
   );

   // State register; POR state follows reset.
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.por <= 1'b1;
         st_reg.pwr <= EFP_RST_PWR;
         st_reg.intg <= EFP_RST_INT;
         st_reg.frac <= EFP_RST_FRAC;
         st_reg.modc <= EFP_RST_MOD;
         st_reg.step <= EFP_RST_STEP;
         st_reg.seed <= EFP_RST_SEED;
         st_reg.cen_sync <= 2'b11;
         st_reg.run <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from flops.
   assign rd_data = st_reg.rdat;
   assign power_down = st_reg.pd;
   assign clocks_run = st_reg.run;
   assign por_busy = st_reg.por;
   assign frac_mode = st_reg.modc[EFP_MOD_FRAC_EN_BIT];
   assign int_ratio = st_reg.intg;
   assign step_count = st_reg.step;
   assign accum_phase = st_reg.ph;
   assign mod_carry = st_reg.cy;
   assign seed_reload = st_reg.load;
endmodule // efp_ctrl

// ---- pkg/efp_pkg.sv ----
package efp_pkg;
   // ---------------------------------------------------------------
   // Register map and field layout
   // ---------------------------------------------------------------
   localparam logic [4:0] EFP_ADDR_RST = 5'h00;
   localparam logic [4:0] EFP_ADDR_PWR = 5'h01;
   localparam logic [4:0] EFP_ADDR_INT = 5'h03;
   localparam logic [4:0] EFP_ADDR_FRAC = 5'h04;
   localparam logic [4:0] EFP_ADDR_MOD = 5'h06;
   localparam logic [4:0] EFP_ADDR_STEP = 5'h0c;
   localparam logic [4:0] EFP_ADDR_SEED = 5'h1a;
   localparam int EFP_DW = 24;
   localparam int EFP_PWR_OVR_BIT = 0;
   localparam int EFP_PWR_REG_BIT = 1;
   localparam int EFP_MOD_FRAC_EN_BIT = 11;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [23:0] EFP_RST_PWR = 24'h00_0001;
   localparam logic [23:0] EFP_RST_INT = 24'h00_0019;
   localparam logic [23:0] EFP_RST_FRAC = 24'h00_0000;
   localparam logic [23:0] EFP_RST_MOD = 24'h00_0000;
   localparam logic [23:0] EFP_RST_STEP = 24'h00_0000;
   localparam logic [23:0] EFP_RST_SEED = 24'h00_0000;
   // Arbitrary neutral identification value.
   localparam logic [23:0] EFP_CHIP_ID = 24'h00_0000;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int EFP_CLK_MHZ = 250;
   localparam int EFP_POR_US = 250;
   localparam int EFP_POR_CYC = EFP_POR_US * EFP_CLK_MHZ;
endpackage

// ---- core/efp_accum.sv ----
`timescale 1ns/10ps
// Fractional phase accumulator with seed reload; holds while gated.
module efp_accum #(
   parameter int W = 24
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic load,
   input wire logic [W-1:0] seed,
   input wire logic [W-1:0] step,
   output logic [W-1:0] phase,
   output logic carry
);
   typedef struct packed {
      logic [W-1:0] acc;
      logic cy;
   } efp_acc_t;
   efp_acc_t st_reg;
   efp_acc_t st_next;
   logic [W:0] sum;

   // Load takes priority so the seed lands before the next update.
   always_comb begin
      st_next = st_reg;
      sum = {1'b0, st_reg.acc} + {1'b0, step};
      if (load) begin
         st_next.acc = seed;
         st_next.cy = 1'b0;
      end else if (run) begin
         st_next.acc = sum[W-1:0];
         st_next.cy = sum[W];
      end else begin
         st_next.cy = 1'b0;
      end
   end

   // State register.
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign phase = st_reg.acc;
   assign carry = st_reg.cy;
endmodule // efp_accum

// ---- dv/efp_props.sv ----
`timescale 1ns/10ps
// Watches the control ports for reload, power-down and reset behaviour.
module efp_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [4:0] wr_addr,
   input wire logic [23:0] wr_data,
   input wire logic chip_enable_pin,
   input wire logic power_down,
   input wire logic clocks_run,
   input wire logic por_busy,
   input wire logic frac_mode,
   input wire logic [23:0] int_ratio,
   input wire logic [23:0] step_count,
   input wire logic [23:0] accum_phase,
   input wire logic seed_reload
);
   logic ok;
   logic [23:0] pwr_reg;
   assign ok = wr_en && !por_busy;
   // Shadow of the power register, so both power-down sources can be judged.
   always_ff @(posedge clk) begin
      if (rst || (ok && wr_addr == 5'h00)) begin
         pwr_reg <= 24'h00_0001;
      end else if (ok && wr_addr == 5'h01) begin
         pwr_reg <= wr_data;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_reload; ok && wr_addr == 5'h04 |=> seed_reload; endproperty
   a_reload: assert property (p_reload) else $error("reload missing");
   property p_clk; clocks_run == !power_down; endproperty
   a_clk: assert property (p_clk) else $error("clocks run in power-down");
   property p_pd_reg; (!pwr_reg[0] && $stable(pwr_reg))[*3] |-> power_down == pwr_reg[1]; endproperty
   a_pd_reg: assert property (p_pd_reg) else $error("register power-down wrong");
   property p_pd_pin;
      (pwr_reg[0] && $stable(pwr_reg) && $stable(chip_enable_pin))[*5] |-> power_down == !chip_enable_pin;
   endproperty
   a_pd_pin: assert property (p_pd_pin) else $error("pin power-down wrong");
   property p_keep; power_down && !wr_en |=> $stable(int_ratio) && $stable(step_count); endproperty
   a_keep: assert property (p_keep) else $error("register lost in power-down");
   property p_soft; ok && wr_addr == 5'h00 |=> int_ratio == 24'h00_0019 && !frac_mode; endproperty
   a_soft: assert property (p_soft) else $error("soft reset incomplete");
   property p_hold; ((!frac_mode || power_down) && !seed_reload)[*4] |-> $stable(accum_phase); endproperty
   a_hold: assert property (p_hold) else $error("accumulator moved while gated");
   property p_por_wr; por_busy && wr_en |=> $stable(int_ratio) && $stable(step_count); endproperty
   a_por_wr: assert property (p_por_wr) else $error("write taken during power-on hold");
endmodule // efp_props

// ---- dv/efp_host.sv ----
`timescale 1ns/10ps
// Register-port host; changes its outputs only at falling edges.
module efp_host (
   input wire logic clk,
   input wire logic [23:0] rd_data,
   output logic wr_en,
   output logic [4:0] wr_addr,
   output logic [23:0] wr_data,
   output logic [4:0] rd_addr
);
   // Idle values from time zero.
   initial begin
      wr_en = 1'b0;
      wr_addr = 5'h00;
      wr_data = 24'h00_0000;
      rd_addr = 5'h00;
   end
   // One write; the data lines are scrambled once the strobe is gone.
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      @(negedge clk);
      wr_en = 1'b1;
      wr_addr = a;
      wr_data = d;
      @(negedge clk);
      wr_en = 1'b0;
      wr_data = ~d;
   endtask
   // Readback is registered, so it is taken two rising edges later.
   task automatic rd(input logic [4:0] a, output logic [23:0] d);
      @(negedge clk);
      rd_addr = a;
      repeat (2) @(posedge clk);
      #1 d = rd_data;
   endtask
endmodule // efp_host

// ---- dv/efp_ctrl_test.sv ----
`timescale 1ns/10ps
// Drives register sequences into the control block and compares its outputs.
module efp_ctrl_test;
   logic clk, rst, pin, we, pd, run, busy, fm, rl, cy;
   logic [4:0] wa, ra;
   logic [23:0] wd, rdat, ir, sc, ph, v;
   int num_errors = 0;
   int comparisons = 0;
   localparam logic [23:0] SEED = 24'h5a_3c71;
   logic [23:0] fr [2] = '{24'h93_8000, 24'h93_eaab};
   logic [4:0] adr [6] = '{5'h01, 5'h03, 5'h04, 5'h0c, 5'h1a, 5'h1f};
   logic [23:0] dft [6] = '{24'h00_0001, 24'h00_0019, 24'h00_0000, 24'h00_0000, 24'h00_0000,
      24'h00_0000};
   efp_host host (.clk, .rd_data(rdat), .wr_en(we), .wr_addr(wa), .wr_data(wd), .rd_addr(ra));
   efp_ctrl #(.POR_CYCLES(20)) uut (.clk, .rst, .wr_en(we), .wr_addr(wa), .wr_data(wd),
      .rd_addr(ra), .chip_enable_pin(pin), .rd_data(rdat), .power_down(pd), .clocks_run(run),
      .por_busy(busy), .frac_mode(fm), .int_ratio(ir), .step_count(sc), .accum_phase(ph),
      .mod_carry(cy), .seed_reload(rl));
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input logic [4:0] a, input logic [23:0] e);
      host.rd(a, v);
      chk("readback", e, v);
   endtask
   task automatic conclude;
      $display("errors %0d, comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Clock and watchdog.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      conclude();
   end
   // Main sequence: power-on hold, exact fractional mode with seed reload, both power-down sources, soft reset.
   initial begin
      rst = 1'b1;
      pin = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      host.wr(5'h03, 24'h00_0055);
      for (int i = 0; i < 100 && busy === 1'b1; i++) @(negedge clk);
      rchk(5'h03, 24'h00_0019);
      host.wr(5'h06, 24'h00_0800);
      host.wr(5'h03, 24'h00_002d);
      host.wr(5'h0c, 24'h00_0c00);
      host.wr(5'h1a, SEED);
      chk("step", 24'h00_0c00, sc);
      rchk(5'h1a, SEED);
      foreach (fr[i]) begin
         host.wr(5'h04, fr[i]);
         chk("reload", 24'h00_0001, {23'h0, rl});
         repeat (2) @(posedge clk);
         #1 chk("phase", SEED, ph);
         repeat (2) @(posedge clk);
         #1 chk("carry", 24'h00_0001, {23'h0, cy});
      end
      @(negedge clk) pin = 1'b0;
      repeat (6) @(negedge clk);
      chk("pin down", 24'h00_0001, {23'h0, pd});
      chk("clocks", 24'h00_0000, {23'h0, run});
      host.wr(5'h0c, 24'h00_0123);
      rchk(5'h0c, 24'h00_0123);
      rchk(5'h03, 24'h00_002d);
      host.wr(5'h01, 24'h00_0002);
      repeat (6) @(negedge clk);
      chk("reg down", 24'h00_0001, {23'h0, pd});
      host.wr(5'h01, 24'h00_0000);
      repeat (6) @(negedge clk);
      chk("pin ignored", 24'h00_0000, {23'h0, pd});
      pin = 1'b1;
      host.wr(5'h00, 24'h00_0003);
      foreach (adr[i]) rchk(adr[i], dft[i]);
      conclude();
   end
endmodule // efp_ctrl_test
bind efp_ctrl efp_props chk_i (.clk, .rst, .wr_en, .wr_addr, .wr_data, .chip_enable_pin,
   .power_down, .clocks_run, .por_busy, .frac_mode, .int_ratio, .step_count, .accum_phase,
   .seed_reload);
